/* hw/rmhsp_serial_port.sv */
// Host serial port: SPI slave or 8N1 UART on one pin group
`timescale 1ns/1ps
`default_nettype none
module rmhsp_serial_port
  import rmhsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        uart_mode,
  input  wire logic [15:0] baud_divisor,
  input  wire logic        spi_sck,
  input  wire logic        spi_select_n,
  input  wire logic        data_in,
  output logic             data_out,
  output logic             sck_select_pullup_en,
  output logic             packet_pending_flag,
  output logic             clear_to_send_flag,
  input  wire logic        cmd_done,
  input  wire rmhsp_beat_t tx_beat,
  output logic             tx_ready,
  output rmhsp_beat_t      rx_beat,
  input  wire logic        rx_ready,
  output logic             rx_overrun,
  output logic             pkt_discard,
  output logic             uart_error
);

  // Reference tick: average 8 MHz out of the system clock
  logic [6:0]  ref_acc;
  logic [15:0] div_cnt;
  logic        ovs_tick;
  wire  [6:0]  acc_sum  = ref_acc + ACC_STEP;
  wire         ref_tick = acc_sum >= ACC_WRAP;
  wire         div_end  = ref_tick && (div_cnt + 16'h0001 >= baud_divisor);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ref_acc  <= 7'h00;
      div_cnt  <= 16'h0000;
      ovs_tick <= 1'b0;
    end
    else
    begin
      ref_acc  <= ref_tick ? acc_sum - ACC_WRAP : acc_sum;
      div_cnt  <= div_end ? 16'h0000 : (ref_tick ? div_cnt + 16'h0001 : div_cnt);
      ovs_tick <= div_end;
    end
  end

  // SPI edge detection; pins are synchronous to clk_sys
  logic sck_q;
  logic sel_q;
  wire  spi_on    = !uart_mode;
  wire  sck_rise  = spi_on && !spi_select_n && spi_sck && !sck_q;
  wire  sck_fall  = spi_on && !spi_select_n && !spi_sck && sck_q;
  wire  sel_fall  = spi_on && !spi_select_n && sel_q;

  // SPI transfer state
  logic       xfer_ok;
  logic       xfer_read;
  logic [2:0] spi_bits;
  logic [7:0] spi_rx_sh;
  logic [7:0] spi_tx_sh;
  logic       spi_done;
  wire        spi_load   = sel_fall || (sck_fall && spi_bits == 3'h0);
  // A busy transfer neither takes a byte nor shows one
  wire        spi_ok     = sel_fall ? !clear_to_send_flag : xfer_ok;
  wire        spi_take   = spi_load && spi_ok && (sel_fall ? packet_pending_flag : xfer_read) && tx_beat.valid;
  wire  [7:0] spi_ld_val = spi_take ? tx_beat.data : 8'h00;
  wire  [7:0] next_rx_sh = {spi_rx_sh[6:0], data_in};

  // UART receiver
  rmhsp_rx_st_t rx_st;
  logic [3:0]   rx_sub;
  logic [2:0]   rx_bits;
  logic [7:0]   rx_sh;
  logic         urx_done;
  wire          rx_at_mid  = ovs_tick && rx_sub == OVS_MID;
  wire          rx_at_end  = ovs_tick && rx_sub == OVS_LAST;

  // UART transmitter
  logic       tx_busy;
  logic [3:0] tx_sub;
  logic [3:0] tx_bits;
  logic [8:0] tx_sh;
  wire        utx_take = uart_mode && !tx_busy && tx_beat.valid;

  // Byte into the two-entry receive buffer
  wire        in_valid = spi_done || urx_done;
  wire  [7:0] in_data  = uart_mode ? rx_sh : spi_rx_sh;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sck_q <= 1'b0;
      sel_q <= 1'b1;
      xfer_ok <= 1'b0;
      xfer_read <= 1'b0;
      spi_bits <= 3'h0;
      spi_rx_sh <= 8'h00;
      spi_tx_sh <= 8'h00;
      spi_done <= 1'b0;
      clear_to_send_flag <= 1'b0;
    end
    else
    begin
      sck_q <= spi_sck;
      sel_q <= spi_select_n;
      spi_done <= 1'b0;
      if (sel_fall)
      begin
        // Busy port drops the whole transfer silently
        xfer_ok   <= !clear_to_send_flag;
        xfer_read <= packet_pending_flag;
        spi_bits  <= 3'h0;
      end
      if (sck_rise)
      begin
        spi_rx_sh <= next_rx_sh;
        spi_bits  <= spi_bits + 3'h1;
        spi_done  <= spi_bits == 3'h7 && xfer_ok && !xfer_read;
      end
      if (spi_load)
        spi_tx_sh <= spi_ld_val;
      else if (sck_fall)
        spi_tx_sh <= {spi_tx_sh[6:0], 1'b0};
      // Set wins over completion in the same cycle
      if (sel_fall)
        clear_to_send_flag <= 1'b1;
      else if (cmd_done)
        clear_to_send_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_st <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_bits <= 3'h0;
      rx_sh <= 8'h00;
      urx_done <= 1'b0;
    end
    else
    begin
      urx_done <= 1'b0;
      if (ovs_tick)
        rx_sub <= rx_sub + 4'h1;
      case (rx_st)
        RX_IDLE:
        begin
          rx_sub <= 4'h0;
          if (uart_mode && !data_in)
            rx_st <= RX_START;
        end
        RX_START:
          if (rx_at_mid)
          begin
            rx_sub <= 4'h0;
            rx_st  <= data_in ? RX_IDLE : RX_DATA; // Glitch rejection
          end
        RX_DATA:
          if (rx_at_end)
          begin
            rx_sh   <= {data_in, rx_sh[7:1]};
            rx_bits <= rx_bits + 3'h1;
            if (rx_bits == 3'h7)
              rx_st <= RX_STOP;
          end
        RX_STOP:
          if (rx_at_end)
          begin
            urx_done <= data_in;
            rx_st    <= RX_IDLE;
          end
        default:
          rx_st <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_busy <= 1'b0;
      tx_sub <= 4'h0;
      tx_bits <= 4'h0;
      tx_sh <= 9'h1ff;
    end
    else if (utx_take)
    begin
      tx_busy <= 1'b1;
      tx_sub  <= 4'h0;
      tx_bits <= 4'h0;
      tx_sh   <= {tx_beat.data, 1'b0};
    end
    else if (tx_busy && ovs_tick)
    begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == OVS_LAST)
      begin
        tx_sh   <= {1'b1, tx_sh[8:1]};
        tx_bits <= tx_bits + 4'h1;
        tx_busy <= tx_bits != 4'(FRAME_BITS - 1);
      end
    end
  end

  // Pin outputs, flags and stream handshakes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      data_out <= 1'b1;
      sck_select_pullup_en <= 1'b0;
      packet_pending_flag <= 1'b0;
      tx_ready <= 1'b0;
    end
    else
    begin
      data_out <= uart_mode ? tx_sh[0] : (spi_load ? spi_ld_val[7] : spi_tx_sh[7]);
      sck_select_pullup_en <= uart_mode;
      packet_pending_flag <= tx_beat.valid && !tx_ready;
      tx_ready <= (utx_take || spi_take) && !tx_ready;
    end
  end

  // Two-entry receive buffer: head drives rx_beat, second entry absorbs a stall
  rmhsp_beat_t spare;
  wire         buf_pop      = rx_beat.valid && rx_ready;
  wire         buf_in_ready = !spare.valid || buf_pop;
  wire         buf_push     = in_valid && buf_in_ready;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_beat <= '0;
      spare <= '0;
      rx_overrun <= 1'b0;
    end
    else
    begin
      rx_overrun <= in_valid && !buf_in_ready;
      if (buf_pop || !rx_beat.valid)
      begin
        rx_beat.valid <= spare.valid || buf_push;
        rx_beat.data  <= spare.valid ? spare.data : in_data;
        // Spare refills in the cycle that it moves up
        spare.valid   <= spare.valid && buf_push;
        spare.data    <= in_data;
      end
      else if (buf_push)
        spare <= {1'b1, in_data};
    end
  end

  // Packet tracking and timeouts in UART mode
  logic        pkt_open;
  logic        err_wait;
  logic [16:0] pkt_cnt;
  logic [15:0] pkt_len;
  logic [11:0] gap;
  wire         ib_hit = pkt_open && ovs_tick && gap == IB_TICKS - 12'h001;
  wire         lb_hit = err_wait && ovs_tick && gap == LB_TICKS - 12'h001;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pkt_open <= 1'b0;
      err_wait <= 1'b0;
      pkt_cnt <= 17'h00000;
      pkt_len <= 16'h0000;
      gap <= 12'h000;
      pkt_discard <= 1'b0;
      uart_error <= 1'b0;
    end
    else
    begin
      pkt_discard <= ib_hit && !urx_done;
      uart_error  <= lb_hit && !urx_done;
      if (urx_done)
      begin
        gap <= 12'h000;
        if (pkt_open)
        begin
          pkt_cnt <= pkt_cnt + 17'h00001;
          if (pkt_cnt == 17'h00000)
            pkt_len[7:0] <= rx_sh;
          if (pkt_cnt == 17'h00001)
            pkt_len[15:8] <= rx_sh;
          if (pkt_cnt + 17'h00001 == {1'b0, pkt_len} + HDR_EXTRA && pkt_cnt > 17'h00001)
            pkt_open <= 1'b0;
        end
        else if (!err_wait && rx_sh == SOP_BYTE)
        begin
          pkt_open <= 1'b1;
          pkt_cnt  <= 17'h00000;
        end
      end
      else if (ib_hit)
      begin
        pkt_open <= 1'b0;
        err_wait <= 1'b1;
        gap      <= gap + 12'h001;
      end
      else if (lb_hit)
      begin
        err_wait <= 1'b0;
        gap      <= 12'h000;
      end
      else if ((pkt_open || err_wait) && ovs_tick)
        gap <= gap + 12'h001;
    end
  end

  AST_CTS_ON_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_fall |=> clear_to_send_flag)
    else $error("busy flag not raised at select");

  AST_CTS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clear_to_send_flag && !cmd_done |=> clear_to_send_flag)
    else $error("busy flag dropped before command completion");

  AST_BUSY_DROPS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_fall && clear_to_send_flag |=> !xfer_ok ##1 !spi_done)
    else $error("transfer accepted while busy");

  AST_PENDING: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tx_beat.valid |=> !packet_pending_flag)
    else $error("pending flag high with nothing queued");

  AST_PULLUP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n && uart_mode |=> sck_select_pullup_en)
    else $error("pull-ups off in UART mode");

  AST_SPI_SAMPLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sck_rise |=> spi_rx_sh[0] == $past(data_in))
    else $error("SPI data not sampled on rising edge");

  AST_SDO_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    spi_on && $past(rst_n) && !spi_load && !$past(sck_fall) |=> $stable(data_out))
    else $error("SPI output changed outside falling edge");

  AST_IB_TIMEOUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ib_hit && !urx_done |=> !pkt_open && err_wait && pkt_discard)
    else $error("inter-byte timeout not acted on");

  AST_LB_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    uart_error |-> $past(err_wait) && $past(gap) == LB_TICKS - 12'h001)
    else $error("error sent before last-byte timer elapsed");

  AST_RESET_IDLE: assert property (@(posedge clk_sys)
    !rst_n |=> !clear_to_send_flag && !rx_beat.valid && rx_st == RX_IDLE && !tx_busy && data_out)
    else $error("reset did not return block to idle");

endmodule
`default_nettype wire

/* hw/rmhsp_pkg.sv */
// Constants and types for the radio modem host serial port
// Overview of operation
// - SPI is slave only; clock, select and data-in are inputs, data-out output.
// - SPI clock idles low between transfers.
// - Data sampled on rising clock edge, changed on following falling edge.
// - Select may be released any time after the last byte is exchanged.
// - In UART mode clock and select are unused inputs with weak pull-ups.
// - UART receives on shared data-in pin and transmits on shared data-out pin.
// - UART frame is fixed: one start, eight data, one stop, no parity.
// - No hardware or in-band software flow control in UART mode.
// - Baud rate configurable; standard rates 9600 to 115200 within 4% error; nearest to 115200 here is 125000, 8.5% off.
// - Baud comes from 8 MHz over sixteen times a 16-bit divisor.
// - Pending flag high while outbound data waits; it selects read or write.
// - Busy flag set at select, held until command completes; new requests dropped.
// - UART gap over 10 byte-times after start-of-packet discards packet, flags error.
// - UART timeout error is sent only after 25 byte-times have passed.
package rmhsp_pkg;

  localparam int CLK_MHZ    = 100;
  localparam int REF_MHZ    = 8;
  localparam int OVS        = 16;
  localparam int FRAME_BITS = 10;
  localparam int BYTE_TICKS = OVS * FRAME_BITS;
  localparam int IB_BYTES   = 10;
  localparam int LB_BYTES   = 25;
  localparam logic [11:0] IB_TICKS = 12'(IB_BYTES * BYTE_TICKS);
  localparam logic [11:0] LB_TICKS = 12'(LB_BYTES * BYTE_TICKS);
  localparam logic [6:0]  ACC_STEP = 7'(REF_MHZ);
  localparam logic [6:0]  ACC_WRAP = 7'(CLK_MHZ);
  localparam logic [3:0]  OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0]  OVS_MID  = 4'(OVS / 2 - 1);
  localparam logic [7:0]  SOP_BYTE = 8'h3c;
  localparam logic [16:0] HDR_EXTRA = 17'h00003;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rmhsp_rx_st_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rmhsp_beat_t;

endpackage

/* test/rmhsp_host_model.sv */
// Host model: SPI master and UART peer for the serial port
`timescale 1ns/1ps
`default_nettype none
module rmhsp_host_model
(
  input  wire logic clk_sys,
  input  wire logic data_out,
  output var logic  spi_sck,
  output var logic  spi_select_n,
  output var logic  data_in
);
  // Half period 30 cycles keeps sck near 1.67 MHz
  localparam int HALF = 30;
  localparam int UBIT = 200;

  initial
  begin
    spi_sck = 1'b0;
    spi_select_n = 1'b1;
    data_in = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic spi_xfer(input logic [7:0] mosi, output logic [7:0] miso);
    spi_select_n <= 1'b0;
    wait_clk(2 * HALF);
    for (int i = 7; i >= 0; i--)
    begin
      data_in <= mosi[i];
      wait_clk(HALF);
      miso[i] = data_out;
      spi_sck <= 1'b1;
      wait_clk(HALF);
      spi_sck <= 1'b0;
    end
    wait_clk(2 * HALF);
    spi_select_n <= 1'b1;
    // Released line must not keep showing the last bit
    data_in <= ~mosi[0];
    wait_clk(2 * HALF);
  endtask

  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      data_in <= f[i];
      wait_clk(UBIT);
    end
  endtask
endmodule
`default_nettype wire

/* test/rmhsp_serial_port_tb_top.sv */
// Self-checking testbench for the host serial port
`timescale 1ns/1ps
`default_nettype none
module rmhsp_serial_port_tb_top;
  import rmhsp_pkg::*;
  logic        clk_sys, rst_n, uart_mode, cmd_done, rx_ready;
  logic        spi_sck, spi_select_n, data_in, data_out, pullup_en;
  logic        pend, cts, tx_ready, rx_overrun, pkt_discard, uart_error;
  logic        ovr_seen = 1'b0;
  logic        txr_seen = 1'b0;
  logic        ovr_clr, tx_go;
  logic [7:0]  miso, tx_byte;
  logic [15:0] baud_div;
  rmhsp_beat_t tx_beat = '0;
  rmhsp_beat_t rx_beat;
  int          error_cnt = 0;
  int          checked = 0;
  // Rows: {expected overrun, mosi byte}; buffer is never drained here
  logic [8:0]  rows [3] = '{9'h081, 9'h0ff, 9'h13c};

  rmhsp_serial_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .uart_mode(uart_mode),
    .baud_divisor(baud_div), .spi_sck(spi_sck), .spi_select_n(spi_select_n),
    .data_in(data_in), .data_out(data_out), .sck_select_pullup_en(pullup_en),
    .packet_pending_flag(pend), .clear_to_send_flag(cts), .cmd_done(cmd_done),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .rx_beat(rx_beat), .rx_ready(rx_ready),
    .rx_overrun(rx_overrun), .pkt_discard(pkt_discard), .uart_error(uart_error));
  rmhsp_host_model host (.clk_sys(clk_sys), .data_out(data_out), .spi_sck(spi_sck),
    .spi_select_n(spi_select_n), .data_in(data_in));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Pulses are caught here so that long tasks do not miss them
  // Sole driver of the core-side byte stream as well
  always @(posedge clk_sys)
  begin
    if (ovr_clr)
      ovr_seen <= 1'b0;
    else if (rx_overrun === 1'b1)
      ovr_seen <= 1'b1;
    if (tx_ready === 1'b1)
    begin
      txr_seen <= 1'b1;
      tx_beat.valid <= 1'b0;
    end
    else if (tx_go)
      tx_beat <= {1'b1, tx_byte};
  end

  task automatic clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic end_sim();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pop(input logic [7:0] exp);
    cmp1("rx valid", 1'b1, rx_beat.valid);
    cmp8("rx data", exp, rx_beat.data);
    rx_ready <= 1'b1;
    clk(1);
    rx_ready <= 1'b0;
    clk(1);
  endtask

  task automatic done_cmd();
    cmd_done <= 1'b1;
    clk(1);
    cmd_done <= 1'b0;
    clk(2);
  endtask

  task automatic wait_hi(input int sel, input int lim);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++)
    begin
      @(posedge clk_sys);
      hit = (sel == 0) ? (pkt_discard === 1'b1) : (sel == 1) ? (uart_error === 1'b1) : (data_out === 1'b0);
    end
    if (!hit)
    begin
      error_cnt++;
      $display("Error wait %0d expected 1 seen 0", sel);
      end_sim();
    end
  endtask

  task automatic queue_tx(input logic [7:0] b);
    tx_byte <= b;
    tx_go <= 1'b1;
    clk(1);
    tx_go <= 1'b0;
  endtask

  // Bits are looked at mid-cell, timed from the start bit's edge
  task automatic uart_tx_check(input logic [7:0] b, input int bit_cyc);
    queue_tx(b);
    wait_hi(2, 20);
    clk(bit_cyc / 2);
    for (int i = 0; i < 9; i++)
    begin
      clk(bit_cyc);
      cmp1("uart tx bit", (i < 8) ? b[i] : 1'b1, data_out);
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    uart_mode = 1'b0;
    cmd_done = 1'b0;
    rx_ready = 1'b0;
    baud_div = 16'h0001;
    ovr_clr = 1'b0;
    tx_go = 1'b0;
    tx_byte = 8'h00;
    clk(12);
    cmp1("reset data_out", 1'b1, data_out);
    cmp1("reset busy", 1'b0, cts);
    cmp1("reset rx valid", 1'b0, rx_beat.valid);
    rst_n <= 1'b1;
    clk(2);
    for (int i = 0; i < 3; i++)
    begin
      ovr_clr <= 1'b1;
      clk(1);
      ovr_clr <= 1'b0;
      host.spi_xfer(rows[i][7:0], miso);
      cmp1("busy", 1'b1, cts);
      done_cmd();
      cmp1("busy clear", 1'b0, cts);
      cmp1("overrun", rows[i][8], ovr_seen);
    end
    pop(rows[0][7:0]);
    pop(rows[1][7:0]);
    cmp1("rx empty", 1'b0, rx_beat.valid);
    host.spi_xfer(8'h55, miso);
    host.spi_xfer(8'h66, miso);
    pop(8'h55);
    cmp1("dropped while busy", 1'b0, rx_beat.valid);
    done_cmd();
    queue_tx(8'ha5);
    clk(3);
    cmp1("pending", 1'b1, pend);
    host.spi_xfer(8'h00, miso);
    cmp8("miso", 8'ha5, miso);
    cmp1("tx taken", 1'b1, txr_seen);
    cmp1("read ignores mosi", 1'b0, rx_beat.valid);
    done_cmd();
    cmp1("pending clear", 1'b0, pend);
    rst_n <= 1'b0;
    uart_mode <= 1'b1;
    clk(12);
    rst_n <= 1'b1;
    clk(2);
    cmp1("pullup", 1'b1, pullup_en);
    cmp1("tx idle", 1'b1, data_out);
    host.uart_send(8'h5a);
    clk(4);
    pop(8'h5a);
    uart_tx_check(8'h96, 200);
    host.uart_send(SOP_BYTE);
    wait_hi(0, 25000);
    wait_hi(1, 40000);
    rst_n <= 1'b0;
    baud_div <= 16'h0002;
    clk(12);
    rst_n <= 1'b1;
    clk(2);
    uart_tx_check(8'hc3, 400);
    end_sim();
  end
endmodule
`default_nettype wire
